// [rtl/ddd_pkg.sv]
// Shared constants and carriers of the down-converter decimation block.
// Assumes a single pclk domain; register byte addresses on a 32-bit APB.
package ddd_pkg;
  localparam int unsigned DDD_PRESETS = 8;
  localparam int unsigned DDD_STAGES = 7;
  localparam int unsigned DDD_DECODES = 6;
  // Register byte addresses
  localparam logic [11:0] DDD_ADDR_CTRL = 12'h000;
  localparam logic [11:0] DDD_ADDR_DELAY = 12'h004;
  localparam logic [11:0] DDD_ADDR_STATUS = 12'h008;
  localparam logic [11:0] DDD_ADDR_FREQ0 = 12'h040;
  localparam logic [11:0] DDD_ADDR_PHASE0 = 12'h060;
  // Control fields
  localparam int unsigned DDD_CTRL_SRC_BIT = 0;
  localparam int unsigned DDD_CTRL_SEL_LSB = 1;
  localparam int unsigned DDD_CTRL_DEC_LSB = 4;
  localparam logic [2:0] DDD_DEC_RESET = 3'h0;
  localparam logic [5:0] DDD_DELAY_RESET = 6'h00;
  // Status fields
  localparam int unsigned DDD_STAT_FLUSH_BIT = 0;
  localparam int unsigned DDD_STAT_PRESET_LSB = 1;
  localparam int unsigned DDD_STAT_ROOM_BIT = 4;
  localparam int unsigned DDD_STAT_LEVEL_LSB = 8;
  // Decimation code -> overall factor, 4/8/10/16/20/32
  localparam int unsigned DDD_DEC_FACTOR [DDD_DECODES] = '{4, 8, 10, 16, 20, 32};
  // Fixed stage order: 7a, 7b, 11, 15, 19, 55, 139
  localparam int unsigned DDD_STG_FACTOR [DDD_STAGES] = '{2, 2, 2, 2, 2, 2, 5};
  localparam logic [6:0] DDD_DEC_MASK [DDD_DECODES] = '{
    7'h30, 7'h2C, 7'h44, 7'h2D, 7'h45, 7'h2F};
  localparam int unsigned DDD_FLUSH_SAMPLES = 256;
  localparam int unsigned DDD_FIFO_DEPTH = 16;
  localparam int unsigned DDD_FIFO_MARGIN = 8;

  typedef struct packed {
    logic signed [17:0] i;
    logic signed [17:0] q;
    logic ovr_i;
    logic ovr_q;
  } ddd_cplx_type;

  typedef struct packed {
    logic [15:0] i_word;
    logic [15:0] q_word;
  } ddd_out_type;
endpackage : ddd_pkg

// [rtl/ddd_dec_stage.sv]
// One complex decimating stage with bypass.
// Assumes clear is synchronous to pclk and in_valid is a one-cycle strobe.
`timescale 1ns/1ps
module ddd_dec_stage #(
  parameter int unsigned FACTOR = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic bypass,
  input wire logic in_valid,
  input wire ddd_pkg::ddd_cplx_type in_data,
  output logic out_valid,
  output ddd_pkg::ddd_cplx_type out_data
);
  logic [2:0] cnt_q;
  logic signed [21:0] sum_i_q, sum_q_q, tot_i, tot_q;
  logic ovr_i_q, ovr_q_q;
  logic last;

  assign last = cnt_q == 3'(FACTOR - 1);
  assign tot_i = sum_i_q + 22'(in_data.i);
  assign tot_q = sum_q_q + 22'(in_data.q);

  function automatic logic signed [17:0] scale(input logic signed [21:0] s);
    logic signed [27:0] p;
    p = 28'(s) * 28'sd13;
    // Boxcar gain removal; the /5 path uses 13/64, about 1.5 % high
    if (FACTOR == 5) begin
      scale = 18'(p >>> 6);
    end else begin
      scale = 18'(s >>> 1);
    end
  endfunction : scale

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      sum_i_q <= '0;
      sum_q_q <= '0;
      ovr_i_q <= 1'b0;
      ovr_q_q <= 1'b0;
    end else if (clear || bypass) begin
      cnt_q <= 3'h0;
      sum_i_q <= '0;
      sum_q_q <= '0;
      ovr_i_q <= 1'b0;
      ovr_q_q <= 1'b0;
    end else if (in_valid) begin
      cnt_q <= last ? 3'h0 : cnt_q + 3'h1;
      sum_i_q <= last ? '0 : tot_i;
      sum_q_q <= last ? '0 : tot_q;
      ovr_i_q <= last ? 1'b0 : (ovr_i_q | in_data.ovr_i);
      ovr_q_q <= last ? 1'b0 : (ovr_q_q | in_data.ovr_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= in_valid && !clear && (bypass || last);
      if (in_valid && bypass) begin
        out_data <= in_data;
      end else if (in_valid && last) begin
        out_data <= '{i: scale(tot_i), q: scale(tot_q),
                      ovr_i: ovr_i_q | in_data.ovr_i, ovr_q: ovr_q_q | in_data.ovr_q};
      end
    end
  end

  AST_STG_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    out_valid && !bypass && !$past(bypass) |=> !out_valid)
    else $error("decimating stage emitted on two adjacent cycles");
endmodule : ddd_dec_stage

// [rtl/ddd_fifo.sv]
// Output sample FIFO with registered read side.
// Assumes DEPTH is a power of two; in_ready leaves MARGIN words of slack.
`timescale 1ns/1ps
module ddd_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned MARGIN = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_d;
  logic push, pop;

  assign push = in_valid && (level < (AW+1)'(DEPTH));
  assign pop = (level != '0) && (!out_valid || out_ready);
  assign cnt_d = level + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
      level <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      level <= cnt_d;
      // Early deassert leaves room for samples still in the chain
      in_ready <= cnt_d <= (AW+1)'(DEPTH - MARGIN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rd_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  AST_FIFO_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo dropped a stalled output word");
endmodule : ddd_fifo

// [rtl/ddd_top.sv]
// Oscillator phase presets, programmable delay and decimation chain.
// Assumes pclk is the sample clock and the mixer feeds one complex word per in_valid.
//
// Notes on behaviour
// - 16-bit phase offset added as upper half
// - Offset LSB is one 65536th of a turn
// - Programmable sample delay inside filter path
// - Delay steps half samples, up to D-0.5
// - Decimation factors 4, 8, 10, 16, 20, 32
// - Stages complex in and out, 18-bit result
// - Output is 15-bit I, Q plus two flags
// - Output rate is input rate over D
// - Chains for 4, 8, 16 from listed stages
// - Chains for 32, 10, 20 from listed stages
// - Frequency is tuning word times clock / 2^32
// - Preset from pins or bits; all accumulators run
// - 139-tap stage by five, others by two
// - Flags sit below upper 15 bits of I, Q
`timescale 1ns/1ps
module ddd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic [2:0] preset_select_pins,
  input wire logic in_valid,
  input wire logic signed [15:0] in_i,
  input wire logic signed [15:0] in_q,
  input wire logic overrange_flag_i,
  input wire logic overrange_flag_q,
  output logic in_ready,
  output logic [31:0] nco_phase,
  output logic out_valid,
  input wire logic out_ready,
  output ddd_pkg::ddd_out_type out_data
);
  localparam int unsigned FLUSHW = $clog2(ddd_pkg::DDD_FLUSH_SAMPLES) + 1;

  // Register state
  logic src_q;
  logic [2:0] preset_select_bits;
  logic [2:0] dec_q;
  logic [5:0] filter_sample_delay;
  logic [31:0] tuning_word_preset [ddd_pkg::DDD_PRESETS];
  logic [15:0] phase_offset_preset [ddd_pkg::DDD_PRESETS];
  logic [31:0] acc_q [ddd_pkg::DDD_PRESETS];
  logic [2:0] pin_s1_q, pin_s2_q;
  logic [2:0] active_sel;
  logic [31:0] acc_sel, freq_sel;
  logic [15:0] ofs_sel;
  logic flush_q;
  logic [FLUSHW-1:0] flush_cnt_q;
  logic [4:0] fifo_level;
  logic wr_en, rd_en, addr_ok;
  logic in_acc;

  // Writes land at the access edge, where the master sees pready
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign in_acc = in_valid && in_ready;

  // APB slave: one wait-free access phase, answer registered in setup
  always_comb begin
    addr_ok = paddr[1:0] == 2'h0 && (paddr == ddd_pkg::DDD_ADDR_CTRL ||
      paddr == ddd_pkg::DDD_ADDR_DELAY || paddr == ddd_pkg::DDD_ADDR_STATUS ||
      paddr[11:5] == ddd_pkg::DDD_ADDR_FREQ0[11:5] ||
      paddr[11:5] == ddd_pkg::DDD_ADDR_PHASE0[11:5]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= 32'h0000_0000;
      if (rd_en && addr_ok) begin
        if (paddr == ddd_pkg::DDD_ADDR_CTRL) begin
          prdata[ddd_pkg::DDD_CTRL_SRC_BIT] <= src_q;
          prdata[ddd_pkg::DDD_CTRL_SEL_LSB +: 3] <= preset_select_bits;
          prdata[ddd_pkg::DDD_CTRL_DEC_LSB +: 3] <= dec_q;
        end else if (paddr == ddd_pkg::DDD_ADDR_DELAY) begin
          prdata[5:0] <= filter_sample_delay;
        end else if (paddr == ddd_pkg::DDD_ADDR_STATUS) begin
          prdata[ddd_pkg::DDD_STAT_FLUSH_BIT] <= flush_q;
          prdata[ddd_pkg::DDD_STAT_PRESET_LSB +: 3] <= active_sel;
          prdata[ddd_pkg::DDD_STAT_ROOM_BIT] <= in_ready;
          prdata[ddd_pkg::DDD_STAT_LEVEL_LSB +: 5] <= fifo_level;
        end else if (paddr[11:5] == ddd_pkg::DDD_ADDR_FREQ0[11:5]) begin
          prdata <= tuning_word_preset[paddr[4:2]];
        end else begin
          prdata[15:0] <= phase_offset_preset[paddr[4:2]];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
      preset_select_bits <= 3'h0;
      dec_q <= ddd_pkg::DDD_DEC_RESET;
      filter_sample_delay <= ddd_pkg::DDD_DELAY_RESET;
    end else if (wr_en && paddr == ddd_pkg::DDD_ADDR_CTRL) begin
      src_q <= pwdata[ddd_pkg::DDD_CTRL_SRC_BIT];
      preset_select_bits <= pwdata[ddd_pkg::DDD_CTRL_SEL_LSB +: 3];
      // Unsupported codes leave the chain as it is
      if (pwdata[ddd_pkg::DDD_CTRL_DEC_LSB +: 3] < 3'(ddd_pkg::DDD_DECODES)) begin
        dec_q <= pwdata[ddd_pkg::DDD_CTRL_DEC_LSB +: 3];
      end
    end else if (wr_en && paddr == ddd_pkg::DDD_ADDR_DELAY) begin
      filter_sample_delay <= pwdata[5:0];
    end
  end

  // Preset pins come from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= preset_select_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign active_sel = src_q ? preset_select_bits : pin_s2_q;
  assign acc_sel = acc_q[active_sel];
  assign freq_sel = tuning_word_preset[active_sel];
  assign ofs_sel = phase_offset_preset[active_sel];

  // Eight accumulators free-run so a preset switch needs no settling
  for (genvar n = 0; n < ddd_pkg::DDD_PRESETS; n++) begin : g_preset
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tuning_word_preset[n] <= 32'h0000_0000;
        phase_offset_preset[n] <= 16'h0000;
      end else if (wr_en && paddr == ddd_pkg::DDD_ADDR_FREQ0 + 12'(4 * n)) begin
        tuning_word_preset[n] <= pwdata;
      end else if (wr_en && paddr == ddd_pkg::DDD_ADDR_PHASE0 + 12'(4 * n)) begin
        phase_offset_preset[n] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_q[n] <= 32'h0000_0000;
      end else begin
        acc_q[n] <= acc_q[n] + tuning_word_preset[n];
      end
    end
  end

  // Offset fills the top 16 bits: one LSB is 2*pi/65536 rad
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_phase <= 32'h0000_0000;
    end else begin
      nco_phase <= acc_sel + {ofs_sel, 16'h0000};
    end
  end

  // Flush on every change of decimation setting
  logic [2:0] dec_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_prev_q <= ddd_pkg::DDD_DEC_RESET;
      flush_q <= 1'b0;
      flush_cnt_q <= '0;
    end else begin
      dec_prev_q <= dec_q;
      if (dec_q != dec_prev_q) begin
        flush_q <= 1'b1;
        flush_cnt_q <= FLUSHW'(ddd_pkg::DDD_FLUSH_SAMPLES);
      end else if (flush_q && in_acc) begin
        flush_cnt_q <= flush_cnt_q - FLUSHW'(1);
        flush_q <= flush_cnt_q != FLUSHW'(1);
      end
    end
  end

  // Delay line, newest at index 0
  localparam int unsigned DLN = 33;
  ddd_pkg::ddd_cplx_type dl_q [DLN];
  ddd_pkg::ddd_cplx_type dly_out_q;
  logic dly_valid_q;
  logic [5:0] dly_lim, dly_eff;
  logic [4:0] dly_int;
  logic signed [18:0] avg_i, avg_q;

  always_comb begin
    dly_lim = 6'(2 * ddd_pkg::DDD_DEC_FACTOR[dec_q] - 1);
    dly_eff = (filter_sample_delay > dly_lim) ? dly_lim : filter_sample_delay;
    dly_int = dly_eff[5:1];
    // Six-bit neighbour index, so tap 31 pairs with 32 and not with 0
    avg_i = (19'(dl_q[dly_int].i) + 19'(dl_q[6'(dly_int) + 6'h01].i)) >>> 1;
    avg_q = (19'(dl_q[dly_int].q) + 19'(dl_q[6'(dly_int) + 6'h01].q)) >>> 1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < DLN; k++) begin
        dl_q[k] <= '0;
      end
    end else if (in_acc) begin
      dl_q[0] <= '{i: 18'(in_i), q: 18'(in_q), ovr_i: overrange_flag_i,
                  ovr_q: overrange_flag_q};
      for (int k = 1; k < DLN; k++) begin
        dl_q[k] <= dl_q[k-1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_valid_q <= 1'b0;
      dly_out_q <= '0;
    end else begin
      dly_valid_q <= in_acc;
      if (in_acc) begin
        dly_out_q <= dl_q[dly_int];
        if (dly_eff[0]) begin
          // Half step by linear interpolation of neighbours
          dly_out_q.i <= 18'(avg_i);
          dly_out_q.q <= 18'(avg_q);
        end
      end
    end
  end

  // Stage chain in fixed order; unused stages pass through
  ddd_pkg::ddd_cplx_type stg_d [ddd_pkg::DDD_STAGES+1];
  logic stg_v [ddd_pkg::DDD_STAGES+1];
  logic [6:0] mask;
  assign mask = ddd_pkg::DDD_DEC_MASK[dec_q];
  assign stg_d[0] = dly_out_q;
  assign stg_v[0] = dly_valid_q;

  for (genvar g = 0; g < ddd_pkg::DDD_STAGES; g++) begin : g_stage
    ddd_dec_stage #(.FACTOR(ddd_pkg::DDD_STG_FACTOR[g])) u_stage (
      .pclk(pclk),
      .presetn(presetn),
      .clear(flush_q),
      .bypass(!mask[g]),
      .in_valid(stg_v[g]),
      .in_data(stg_d[g]),
      .out_valid(stg_v[g+1]),
      .out_data(stg_d[g+1])
    );
  end

  ddd_pkg::ddd_out_type push_word;
  logic push;
  assign push = stg_v[ddd_pkg::DDD_STAGES] && !flush_q;
  assign push_word.i_word = {stg_d[ddd_pkg::DDD_STAGES].i[17:3],
                             stg_d[ddd_pkg::DDD_STAGES].ovr_i};
  assign push_word.q_word = {stg_d[ddd_pkg::DDD_STAGES].q[17:3],
                             stg_d[ddd_pkg::DDD_STAGES].ovr_q};

  ddd_fifo #(
    .WIDTH(32),
    .DEPTH(ddd_pkg::DDD_FIFO_DEPTH),
    .MARGIN(ddd_pkg::DDD_FIFO_MARGIN)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(push_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data),
    .level(fifo_level)
  );

  AST_PHASE_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(active_sel) && $stable(freq_sel) && $stable(ofs_sel) && !$rose(presetn)
    |=> nco_phase - $past(nco_phase) == $past(freq_sel))
    else $error("phase did not advance by the tuning word");
  AST_PHASE_OFS: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(active_sel) && $stable(freq_sel) && $changed(ofs_sel)
    |=> nco_phase[15:0] - $past(nco_phase[15:0]) == $past(freq_sel[15:0]))
    else $error("phase offset disturbed the lower half of the phase");
  AST_SEL_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    src_q |-> active_sel == preset_select_bits)
    else $error("preset not taken from select bits");
  AST_DELAY_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
    dly_eff <= 6'(2 * ddd_pkg::DDD_DEC_FACTOR[dec_q] - 1))
    else $error("delay beyond decimation minus one half");
  AST_FLUSH_START: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(dec_q) |=> flush_q [*2])
    else $error("decimation change did not start a flush");
  AST_FLUSH_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    flush_q |-> !push ##1 !stg_v[ddd_pkg::DDD_STAGES])
    else $error("sample pushed during flush");
  AST_OUT_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
    push && $stable(mask) |=> !push [*3])
    else $error("chain output closer than the smallest decimation");
  AST_OVR_LSB: assert property (@(posedge pclk) disable iff (!presetn)
    push |-> push_word.i_word[0] == stg_d[ddd_pkg::DDD_STAGES].ovr_i &&
             push_word.q_word[0] == stg_d[ddd_pkg::DDD_STAGES].ovr_q)
    else $error("over-range flag not in word LSB");
  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not exactly one access cycle");
endmodule : ddd_top

// [test/ddd_link_sink.sv]
// Far-side model: the serial link framer taking complex output words.
// Assumes one word per out_valid && out_ready edge; expect_word set by the bench.
`timescale 1ns/1ps
module ddd_link_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic slow,
  input wire ddd_pkg::ddd_out_type expect_word,
  input wire logic out_valid,
  input wire ddd_pkg::ddd_out_type out_data,
  output logic out_ready,
  output logic [15:0] n_words,
  output logic [15:0] n_bad
);
  logic [7:0] lfsr_q;
  logic waiting_q;
  ddd_pkg::ddd_out_type held_q;
  logic bad_word;
  logic bad_hold;

  assign bad_word = out_valid && out_ready && (out_data !== expect_word);
  // An offered word must not change before it is taken
  assign bad_hold = waiting_q && (out_data !== held_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= 8'h5A;
      out_ready <= 1'b0;
      n_words <= 16'h0000;
      n_bad <= 16'h0000;
      waiting_q <= 1'b0;
      held_q <= '0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      // Slow mode takes words on a pseudo-random half of the cycles
      out_ready <= !stall && (slow ? lfsr_q[0] : 1'b1);
      if (out_valid && out_ready) begin
        n_words <= n_words + 16'h0001;
      end
      n_bad <= n_bad + 16'(bad_word) + 16'(bad_hold);
      waiting_q <= out_valid && !out_ready;
      held_q <= out_data;
    end
  end
endmodule : ddd_link_sink

// [test/test_ddc_decimation_phase_delay.sv]
// Self-checking bench of the decimation, phase offset and delay block.
// Assumes ddd_top on APB at 40 MHz; the link sink model stands at the output.
`timescale 1ns/1ps
module test_ddc_decimation_phase_delay;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, nco_phase, rd, seed = 32'h0000004B;
  logic pready, pslverr, in_ready, out_valid, out_ready, stall = 1'b0, slow = 1'b0;
  logic [2:0] preset_select_pins = 3'h0;
  logic in_valid = 1'b0, ovi = 1'b0, ovq = 1'b0, saw_low = 1'b0;
  logic signed [15:0] in_i = 16'sh0000, in_q = 16'sh0000;
  logic [15:0] n_words, n_bad, base;
  logic [15:0] ofs [8];
  ddd_pkg::ddd_out_type out_data, exp_word;
  int failures = 0, n_checks = 0;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (in_ready === 1'b0) saw_low = 1'b1;

  ddd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .preset_select_pins(preset_select_pins), .in_valid(in_valid),
    .in_i(in_i), .in_q(in_q), .overrange_flag_i(ovi), .overrange_flag_q(ovq),
    .in_ready(in_ready), .nco_phase(nco_phase), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  ddd_link_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow),
    .expect_word(exp_word), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .n_words(n_words), .n_bad(n_bad));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Zero samples give zero I/Q, so only the flag bits remain in each word
  function automatic logic [31:0] word_of(input logic fi, input logic fq);
    return {15'h0000, fi, 15'h0000, fq};
  endfunction : word_of

  function automatic logic [15:0] outs_of(input int n, input int d);
    return 16'(n / d);
  endfunction : outs_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Entered just after a rising edge; leaves one idle edge behind it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic exp_err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    check(32'(pslverr), 32'(exp_err), "bus error flag");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Pushes n accepted samples with random gaps; random data only if noisy
  task automatic feed(input int n, input logic noisy);
    int k;
    logic [31:0] r;
    k = 0;
    while (k < n) begin
      r = rnd();
      in_valid <= (r[1:0] != 2'h0);
      in_i <= noisy ? r[31:16] : 16'sh0000;
      in_q <= noisy ? r[15:0] : 16'sh0000;
      @(posedge pclk);
      if (in_valid === 1'b1 && in_ready === 1'b1) k++;
    end
    in_valid <= 1'b0;
    @(posedge pclk);
  endtask : feed

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    int c, d, n;
    logic [31:0] r, p0;
    exp_word = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ddd_pkg::DDD_ADDR_CTRL, 32'h0, 1'b0);
    check(rd, 32'h00000000, "control reset");
    apb(1'b0, ddd_pkg::DDD_ADDR_DELAY, 32'h0, 1'b0);
    check(rd, 32'(ddd_pkg::DDD_DELAY_RESET), "delay reset");
    apb(1'b0, 12'h100, 32'h0, 1'b1);
    check(rd, 32'h00000000, "unmapped read data");
    // Largest (one LSB short of a full turn) and half-turn corners, then random offsets
    for (n = 0; n < 8; n++) begin
      r = rnd();
      ofs[n] = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h8000 : r[15:0];
      // Offsets rewritten only before any link data flows
      apb(1'b1, ddd_pkg::DDD_ADDR_PHASE0 + 12'(4 * n), {r[31:16], ofs[n]}, 1'b0);
    end
    for (n = 0; n < 8; n++) begin
      apb(1'b1, ddd_pkg::DDD_ADDR_CTRL, {28'h0, 3'(n), 1'b1}, 1'b0);
      repeat (3) @(posedge pclk);
      check(nco_phase, {ofs[n], 16'h0000}, "phase by select bits");
    end
    apb(1'b1, ddd_pkg::DDD_ADDR_CTRL, 32'h0, 1'b0);
    for (n = 0; n < 8; n++) begin
      preset_select_pins <= 3'(7 - n);
      repeat (6) @(posedge pclk);
      check(nco_phase, {ofs[7 - n], 16'h0000}, "phase by select pins");
      apb(1'b0, ddd_pkg::DDD_ADDR_STATUS, 32'h0, 1'b0);
      check(32'(rd[3:1]), 32'(7 - n), "active preset");
    end
    r = rnd();
    // Basic tuning only, so no rational divider is programmed
    apb(1'b1, ddd_pkg::DDD_ADDR_FREQ0 + 12'h00C, r, 1'b0);
    apb(1'b1, ddd_pkg::DDD_ADDR_CTRL, 32'h7, 1'b0);
    repeat (3) @(posedge pclk);
    p0 = nco_phase;
    @(posedge pclk);
    check(nco_phase - p0, r, "phase step per cycle");
    // Each code differs from the one before, so every change flushes
    for (n = 1; n <= 6; n++) begin
      c = n % 6;
      d = ddd_pkg::DDD_DEC_FACTOR[c];
      r = rnd();
      ovi <= r[0];
      ovq <= r[1];
      slow <= r[2];
      exp_word = word_of(r[0], r[1]);
      apb(1'b1, ddd_pkg::DDD_ADDR_CTRL, {25'h0, 3'(c), 4'h1}, 1'b0);
      apb(1'b0, ddd_pkg::DDD_ADDR_STATUS, 32'h0, 1'b0);
      check(32'(rd[0]), 32'h1, "flush after code change");
      apb(1'b0, ddd_pkg::DDD_ADDR_CTRL, 32'h0, 1'b0);
      check(32'(rd[6:4]), 32'(c), "decimation code");
      apb(1'b1, ddd_pkg::DDD_ADDR_DELAY, 32'(2 * d - 1), 1'b0);
      apb(1'b0, ddd_pkg::DDD_ADDR_DELAY, 32'h0, 1'b0);
      check(rd, 32'(2 * d - 1), "largest delay");
      apb(1'b1, ddd_pkg::DDD_ADDR_DELAY, 32'h0, 1'b0);
      // Noise only early in the flush, far beyond the longest delay
      feed(ddd_pkg::DDD_FLUSH_SAMPLES / 2, 1'b1);
      feed(ddd_pkg::DDD_FLUSH_SAMPLES / 2, 1'b0);
      repeat (40) @(posedge pclk);
      base = n_words;
      if (c == 0) begin
        // Stalled link fills the buffer until it refuses, then drains
        stall <= 1'b1;
        fork
          feed(12 * d, 1'b0);
          begin
            repeat (150) @(posedge pclk);
            stall <= 1'b0;
          end
        join
        check(32'(saw_low), 32'h1, "buffer refused input");
      end else begin
        feed(4 * d, 1'b0);
      end
      repeat (120) @(posedge pclk);
      check(32'(n_words - base), 32'(outs_of(((c == 0) ? 12 : 4) * d, d)),
            "outputs per inputs");
      check(32'(n_bad), 32'h0, "output word layout");
    end
    apb(1'b1, ddd_pkg::DDD_ADDR_CTRL, 32'h00000061, 1'b0);
    apb(1'b0, ddd_pkg::DDD_ADDR_CTRL, 32'h0, 1'b0);
    check(32'(rd[6:4]), 32'h0, "reserved code ignored");
    wrap_up();
  end
endmodule : test_ddc_decimation_phase_delay
